/* File: rtl/hth_pkg.sv */
package hth_pkg;

    // Handler port timing, as printed
    localparam int unsigned CLK_FREQ_MHZ     = 200;
    localparam int unsigned TRIG_MIN_LOW_NS  = 1000;   // Least low time of a start or stop pulse
    localparam int unsigned TRIG_GAP_MIN_NS  = 0;      // Least gap from completion to next trigger
    localparam int unsigned TRIG_MIN_LOW_CYC =
        (TRIG_MIN_LOW_NS * CLK_FREQ_MHZ + 999) / 1000;

    // Input conditioning depth
    localparam int unsigned SYNC_STAGES = 3;

    // Reset levels of the handler outputs (all deasserted: active-low pins high, busy low)
    localparam logic        EOC_N_RST  = 1'b1;
    localparam logic        BUSY_RST   = 1'b0;
    localparam logic        PASS_N_RST = 1'b1;
    localparam logic        FAIL_N_RST = 1'b1;

    // Test sequencer states
    typedef enum logic [1:0] {
        HTH_IDLE,
        HTH_CONVERT,
        HTH_EVALUATE
    } hth_state_t;

endpackage

/* File: rtl/hth_edge_sync.sv */
`timescale 1ns/100ps

// Brings an active-low handler pin into the clock domain and flags its release
module hth_edge_sync (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic pin_n,
    output logic      rise
);

    logic [hth_pkg::SYNC_STAGES-1:0] sync_ff;
    logic                            level_ff;
    logic                            agree;

    // Stage 0 feeds stage 1 only; metastability stays off the compare
    always_ff @(posedge clock) begin
        if (reset) begin
            sync_ff  <= {hth_pkg::SYNC_STAGES{1'b1}};
            level_ff <= 1'b1;
        end else begin
            sync_ff <= {sync_ff[hth_pkg::SYNC_STAGES-2:0], pin_n};
            if (agree) begin
                level_ff <= sync_ff[2];
            end
        end
    end

    // A change counts once stages 1 and 2, the last two, agree
    assign agree = (sync_ff[1] == sync_ff[2]);
    assign rise  = agree && sync_ff[2] && !level_ff;  // Low-to-high release

endmodule // hth_edge_sync

/* File: rtl/hth_handler_port.sv */
// What this block does
// - Slash-named handler signals are active low.
// - Assert end-of-conversion when conversion finishes.
// - Results valid only after busy drops.
// - Busy high until calculate, compare, display done.
// - External mode: start on start-pin rising edge.
// - Stop-pin rising edge aborts running test.
// - Next trigger allowed right after completion.
// - Verdict held from completion until next trigger.
// - Triggers during a test are ignored.
`timescale 1ns/100ps

module hth_handler_port (
    input  wire logic clock,
    input  wire logic reset,
    // Handler pins
    input  wire logic start_n,
    input  wire logic stop_n,
    output logic      eoc_n,
    output logic      busy,
    output logic      pass_n,
    output logic      fail_n,
    // Instrument side
    input  wire logic ext_trig_mode,
    input  wire logic int_trig,
    output logic      test_start,
    output logic      test_abort,
    input  wire logic conv_done,
    input  wire logic eval_done,
    input  wire logic eval_pass,
    output logic      trig_ignored
);

    // Sequencer and registered pins
    hth_pkg::hth_state_t state_ff;
    hth_pkg::hth_state_t nxt_state;
    logic                eoc_n_ff;
    logic                nxt_eoc_n;
    logic                busy_ff;
    logic                nxt_busy;
    logic                pass_n_ff;
    logic                nxt_pass_n;
    logic                fail_n_ff;
    logic                nxt_fail_n;

    // Conditioned pin events and qualified requests
    logic                start_rise;
    logic                stop_rise;
    logic                ext_start;
    logic                int_start;
    logic                any_trig;
    logic                in_test;
    logic                accept;
    logic                abort;

    // Phase ends
    logic                conv_end;
    logic                eval_end;

    // A phase ends on its own done strobe; a stop in the same cycle wins,
    // so an aborted test never leaves a half-written result behind
    function automatic logic phase_end(
        input hth_pkg::hth_state_t now,
        input hth_pkg::hth_state_t phase,
        input logic                done,
        input logic                stop
    );
        return (now == phase) && done && !stop;
    endfunction

    // One active-low verdict pin: cleared by a trigger, loaded at completion,
    // else held; both pins share it so their clear and load cannot drift apart
    function automatic logic verdict_n(
        input logic clear,
        input logic load,
        input logic held_n,
        input logic win
    );
        logic res_n;
        res_n = held_n;
        if (clear) begin
            res_n = 1'b1;
        end else if (load) begin
            res_n = !win;
        end
        return res_n;
    endfunction

    // Pin conditioning; pulse width is the handler's duty
    hth_edge_sync u_start_sync (
        .clock (clock),
        .reset (reset),
        .pin_n (start_n),
        .rise  (start_rise)
    );

    hth_edge_sync u_stop_sync (
        .clock (clock),
        .reset (reset),
        .pin_n (stop_n),
        .rise  (stop_rise)
    );

    // Trigger sources never mix: a pin edge in internal mode, or an
    // internal request in external mode, is simply not a trigger
    assign ext_start    = start_rise && ext_trig_mode;
    assign int_start    = int_trig && !ext_trig_mode;
    assign any_trig     = ext_start || int_start;

    // Acceptance only from idle; anything else is dropped and flagged
    assign in_test      = (state_ff != hth_pkg::HTH_IDLE);
    assign accept       = any_trig && !in_test;  // Idle at once: zero gap
    assign trig_ignored = any_trig && in_test;
    assign abort        = stop_rise && in_test;
    assign test_start   = accept;
    assign test_abort   = abort;

    // Phase completions for the output registers; the sequencer tests abort
    // ahead of conv_done and ends evaluate on abort or eval_done alike, so its moves match these ends
    assign conv_end = phase_end(state_ff, hth_pkg::HTH_CONVERT, conv_done, abort);
    assign eval_end = phase_end(state_ff, hth_pkg::HTH_EVALUATE, eval_done, abort);

    // Sequencer: convert, then evaluate, then idle; a stop in either
    // phase goes straight back to idle
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            hth_pkg::HTH_IDLE: begin
                if (accept) begin
                    nxt_state = hth_pkg::HTH_CONVERT;
                end
            end
            hth_pkg::HTH_CONVERT: begin
                if (abort) begin
                    nxt_state = hth_pkg::HTH_IDLE;
                end else if (conv_done) begin
                    nxt_state = hth_pkg::HTH_EVALUATE;
                end
            end
            hth_pkg::HTH_EVALUATE: begin
                if (abort || eval_done) begin
                    nxt_state = hth_pkg::HTH_IDLE;
                end
            end
            default: begin
                nxt_state = hth_pkg::HTH_IDLE;
            end
        endcase
    end

    // End of conversion: released on trigger, set at conversion end
    assign nxt_eoc_n = accept   ? 1'b1 :
                       conv_end ? 1'b0 :
                       eoc_n_ff;

    // Busy follows the next state: high from the edge after accept until
    // the edge that loads the verdict, or the edge after a stop
    assign nxt_busy = (nxt_state != hth_pkg::HTH_IDLE);

    // Verdicts land with busy falling, so they are valid once busy is low
    // A trigger clears both pins before a new result can load one
    assign nxt_pass_n = verdict_n(accept, eval_end, pass_n_ff, eval_pass);
    assign nxt_fail_n = verdict_n(accept, eval_end, fail_n_ff, !eval_pass);

    // Sequencer state; reset parks it idle so no test is pending
    always_ff @(posedge clock) begin
        if (reset) begin
            state_ff <= hth_pkg::HTH_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // End of conversion; stays asserted through evaluation and idle so the
    // handler may swap parts early, until the next trigger releases it
    always_ff @(posedge clock) begin
        if (reset) begin
            eoc_n_ff <= hth_pkg::EOC_N_RST;
        end else begin
            eoc_n_ff <= nxt_eoc_n;
        end
    end

    // Busy register; a flop of its own so the pin is glitch free even
    // though the state may be re-encoded later
    always_ff @(posedge clock) begin
        if (reset) begin
            busy_ff <= hth_pkg::BUSY_RST;
        end else begin
            busy_ff <= nxt_busy;
        end
    end

    // Pass pin register; holds across idle time until the next trigger,
    // so a slow handler still reads the verdict
    always_ff @(posedge clock) begin
        if (reset) begin
            pass_n_ff <= hth_pkg::PASS_N_RST;
        end else begin
            pass_n_ff <= nxt_pass_n;
        end
    end

    // Fail pin register; loaded on the same edge as the pass pin, so the
    // two are never seen both asserted
    always_ff @(posedge clock) begin
        if (reset) begin
            fail_n_ff <= hth_pkg::FAIL_N_RST;
        end else begin
            fail_n_ff <= nxt_fail_n;
        end
    end

    // Pins come straight from flops, so the handler never sees a glitch
    assign eoc_n  = eoc_n_ff;
    assign busy   = busy_ff;
    assign pass_n = pass_n_ff;
    assign fail_n = fail_n_ff;

endmodule // hth_handler_port

/* File: dv/hth_port_monitor.sv */
`timescale 1ns/100ps
module hth_port_monitor (
    input wire logic clock, reset, start_n, stop_n, eoc_n, busy, pass_n, fail_n,
    input wire logic ext_trig_mode, int_trig, test_start, test_abort,
    input wire logic conv_done, eval_done, eval_pass, trig_ignored
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Accept step, then busy with verdicts cleared
    sequence s_accept;
        test_start ##1 (busy && eoc_n && pass_n && fail_n);
    endsequence
    sequence s_abort;
        busy ##1 !busy;
    endsequence
    AST_ACCEPT: assert property (test_start |-> s_accept) else $error("bad accept");
    AST_START_IDLE: assert property (test_start |-> !busy) else $error("start in test");
    AST_IGNORE: assert property (trig_ignored |-> busy && !test_start) else $error("ign");
    AST_EOC: assert property ($fell(eoc_n) |-> $past(conv_done) && busy) else $error("eoc");
    AST_EXCL: assert property (pass_n || fail_n) else $error("both verdicts");
    AST_DONE: assert property ($fell(busy) |-> $past(eval_done) || $past(test_abort))
        else $error("early busy drop");
    AST_VERDICT: assert property ($fell(busy) && $past(eval_done) &&
        !$past(test_abort) |-> pass_n == !$past(eval_pass) && fail_n == $past(eval_pass))
        else $error("verdict");
    AST_HOLD: assert property (!busy && !test_start |=> $stable({pass_n, fail_n}))
        else $error("verdict moved");
    AST_ABORT: assert property (test_abort |-> s_abort) else $error("abort");
    AST_SYNC: assert property (test_start && ext_trig_mode |->
        $past(start_n) && $past(start_n, 2)) else $error("start too early");
endmodule // hth_port_monitor
bind hth_handler_port hth_port_monitor hth_port_monitor_i (.clock(clock), .reset(reset),
    .start_n(start_n), .stop_n(stop_n), .eoc_n(eoc_n), .busy(busy), .pass_n(pass_n),
    .fail_n(fail_n), .ext_trig_mode(ext_trig_mode), .int_trig(int_trig),
    .test_start(test_start), .test_abort(test_abort), .conv_done(conv_done),
    .eval_done(eval_done), .eval_pass(eval_pass), .trig_ignored(trig_ignored));

/* File: dv/hth_handler_model.sv */
`timescale 1ns/100ps
module hth_handler_model (
    input  wire logic clock,
    input  wire logic req,
    input  wire logic sel,
    output logic      start_n,
    output logic      stop_n
);
    int   n = 0;
    logic s = 1'b0;
    // Pulse held low the least legal time; released pin is pulled high.
    // Request taken on the rising edge, clear of the bench's falling-edge drive
    always @(posedge clock) begin
        if (req) begin
            n <= int'(hth_pkg::TRIG_MIN_LOW_CYC);
            s <= sel;
        end else if (n > 0) begin
            n <= n - 1;
        end
    end
    assign start_n = !(n > 0 && !s);
    assign stop_n  = !(n > 0 && s);
endmodule // hth_handler_model

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    logic clock = 0, reset = 1, ext = 0, itr = 0, cdn = 0, edn = 0, eps = 0, req = 0, sel = 0;
    logic start_n, stop_n, eoc_n, busy, pass_n, fail_n, ts, ta, ti;
    int   bad_count = 0, num_checks = 0, cyc = 0, nts = 0, nta = 0, k;
    logic [3:0] rows [4] = '{4'h2, 4'h5, 4'ha, 4'hd}; // ext, pass, pass_n, fail_n
    initial forever #2.5 clock = ~clock;
    hth_handler_port hth_handler_port_i (.clock(clock), .reset(reset), .start_n(start_n),
        .stop_n(stop_n), .eoc_n(eoc_n), .busy(busy), .pass_n(pass_n), .fail_n(fail_n),
        .ext_trig_mode(ext), .int_trig(itr), .test_start(ts), .test_abort(ta),
        .conv_done(cdn), .eval_done(edn), .eval_pass(eps), .trig_ignored(ti));
    hth_handler_model hth_handler_model_i (.clock(clock), .req(req), .sel(sel),
        .start_n(start_n), .stop_n(stop_n));
    // Accept counter and hang guard; a full run needs about 1100 cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (ts) nts <= nts + 1;
        if (ta) nta <= nta + 1;
        if (cyc == 5000) begin
            bad_count++;
            conclude();
        end
    end
    task chk(logic [2:0] s, logic [2:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value at %0t: %h expected %h", $time, s, e);
        end
    endtask
    task trig(logic x);
        int n;
        n = nts;
        if (x) {sel, req} = 2'h1;
        else itr = 1;
        @(negedge clock) {req, itr} = 2'h0;
        for (k = 0; k < 300 && nts == n; k++) @(negedge clock);
        chk({busy, pass_n, fail_n}, 3'h7);
    endtask
    task conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clock);
        reset = 0;
        chk({eoc_n, busy, pass_n & fail_n}, 3'h5);
        foreach (rows[i]) begin
            ext = rows[i][3];
            trig(rows[i][3]);
            cdn = 1;
            @(negedge clock) cdn = 0;
            chk({eoc_n, busy, pass_n & fail_n}, 3'h3);
            {edn, eps} = {1'b1, rows[i][2]};
            @(negedge clock) edn = 0;
            chk({busy, pass_n, fail_n}, {1'b0, rows[i][1:0]});
            $display("row %0d done", i);
        end
        // Second trigger mid-test is dropped, then the stop pin aborts
        ext = 0;
        trig(0);
        itr = 1;
        #1 chk({ti, ts, busy}, 3'h5);
        @(negedge clock) {itr, sel, req} = 3'h3;
        @(negedge clock) req = 0;
        for (k = 0; k < 300 && busy; k++) @(negedge clock);
        chk({busy, eoc_n, pass_n & fail_n}, 3'h3);
        chk(nta[2:0], 3'h1);
        $display("ignore and abort done");
        // Refused: pin start in internal mode, stop while idle, internal start in external mode
        {sel, req} = 2'h1;
        @(negedge clock) req = 0;
        repeat (210) @(negedge clock);
        {sel, req} = 2'h3;
        @(negedge clock) req = 0;
        repeat (210) @(negedge clock);
        {ext, itr} = 2'h3;
        @(negedge clock) itr = 0;
        @(negedge clock);
        chk(nts[2:0], 3'h5);
        chk(nta[2:0], 3'h1);
        chk({busy, pass_n, fail_n}, 3'h3);
        $display("refused requests done");
        conclude();
    end
endmodule // tb_top
